// ===== hdl/pcps_pkg.sv
// Purpose: Constants for the performance counter and precise sampling block
// Assumes: APB register access, 40 MHz core clock
// Notes: Register offsets are byte addresses of aligned 32-bit words
package pcps_pkg;

	// ---------------------------------------------
	// Counter geometry
	// ---------------------------------------------
	localparam int PCPS_CTR_W = 40;
	localparam int PCPS_NUM_GP = 2;
	localparam int PCPS_NUM_FIX = 3;
	localparam int PCPS_NUM_CTR = 5;
	localparam logic [7:0] PCPS_ARCH_VER = 8'h03;

	// ---------------------------------------------
	// Event-select fields
	// ---------------------------------------------
	localparam int PCPS_ES_EVT_LSB = 0;
	localparam int PCPS_ES_UM_LSB = 8;
	localparam int PCPS_ES_ANY_BIT = 21;
	localparam int PCPS_ES_EN_BIT = 22;
	localparam logic [31:0] PCPS_ES_WMASK = 32'hFFDFFFFF;

	// ---------------------------------------------
	// Precise-capable events and off-core response event
	// ---------------------------------------------
	localparam logic [7:0] PCPS_EV_BR = 8'hC4;
	localparam logic [7:0] PCPS_EV_MISP = 8'hC5;
	localparam logic [7:0] PCPS_EV_MEM = 8'h04;
	localparam logic [7:0] PCPS_EV_REHAB = 8'h03;
	localparam logic [7:0] PCPS_EV_OFFCORE = 8'hB7;
	localparam logic [7:0] PCPS_UM_OFF0 = 8'h01;
	localparam logic [7:0] PCPS_UM_OFF1 = 8'h02;

	// ---------------------------------------------
	// Record layout
	// ---------------------------------------------
	localparam int PCPS_REC_WORDS = 24;
	localparam logic [7:0] PCPS_REC_BYTES = 8'hC0;
	localparam int PCPS_SLOT_FLAGS = 0;
	localparam int PCPS_SLOT_IP = 1;
	localparam int PCPS_SLOT_GPR0 = 2;
	localparam int PCPS_NUM_GPR = 16;
	localparam int PCPS_SLOT_STATUS = 18;
	localparam int PCPS_SLOT_CAUSE = 22;

	// ---------------------------------------------
	// Register map
	// ---------------------------------------------
	localparam logic [11:0] PCPS_A_ES0 = 12'h000;
	localparam logic [11:0] PCPS_A_ES1 = 12'h004;
	localparam logic [11:0] PCPS_A_STATUS = 12'h008;
	localparam logic [11:0] PCPS_A_OVFCLR = 12'h00C;
	localparam logic [11:0] PCPS_A_GCTRL = 12'h010;
	localparam logic [11:0] PCPS_A_PSEN = 12'h014;
	localparam logic [11:0] PCPS_A_BASE = 12'h018;
	localparam logic [11:0] PCPS_A_CAP = 12'h01C;
	localparam logic [11:0] PCPS_A_OFF0 = 12'h020;
	localparam logic [11:0] PCPS_A_OFF1 = 12'h024;
	localparam logic [11:0] PCPS_A_FIXCTL = 12'h028;
	localparam logic [11:0] PCPS_A_PEND = 12'h02C;
	localparam logic [11:0] PCPS_A_CTR_BASE = 12'h040;

	typedef enum logic [1:0] {PCPS_IDLE, PCPS_WRITE} pcps_state_t;

endpackage

// ===== hdl/pcps_rec_mem.sv
// Purpose: Staging memory for one precise sample record
// Assumes: One write port, one registered read port
// Notes: Read data come out of a register
`timescale 1ns/1ps
module pcps_rec_mem #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 24,
	parameter int AW = 5
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge clk) begin
		if (ce && wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else if (ce) begin
			rd_data <= mem_q[rd_addr];
		end
	end

endmodule

// ===== hdl/pcps_top.sv
// Purpose: Performance counters with precise sampling on the first counter
// Assumes: APB slave at 40 MHz, memory sink accepts words with a ready
// Notes: Records are 24 64-bit words streamed to the save area
`timescale 1ns/1ps

// What this block does
// (RULE1) Two general and three fixed counters
// (RULE2) Counters 40 bits, width reported 23:16
// (RULE3) General counters count their selected event
// (RULE4) All-threads qualifier bit 21 ignored
// (RULE5) Report architectural monitoring version 3
// (RULE6) Precise sampling only on counter zero
// (RULE7) Record holds state after causing instruction
// (RULE8) Accept branch retired events C4H masks
// (RULE9) Accept mispredict retired events C5H masks
// (RULE10) Accept memory ops 04H, rehab 03H
// (RULE11) Record fields 64 bits, consecutive offsets
// (RULE12) Flags, pointer, sixteen registers, status order
// (RULE13) Software waits quietly before reconfiguring
// (RULE14) Pending records finish at old base
// (RULE15) Two off-core response qualification registers
// (RULE16) Pair counters for average latency
// (RULE17) Status shows overflows, control clears them
// (RULE18) Causing instruction address at 0xB0
// (RULE19) Reserved record slots written as zero
module pcps_top
	import pcps_pkg::*;
#(
	parameter int CW = PCPS_CTR_W
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [7:0] EVT_CODE,
	input wire logic [7:0] EVT_UMASK,
	input wire logic EVT_VALID,
	input wire logic [2:0] FIX_EVT,
	input wire logic [7:0] LAT_WEIGHT,
	input wire logic RETIRE_VALID,
	input wire logic [63:0] ARCH_FLAGS,
	input wire logic [63:0] ARCH_IP,
	input wire logic [1023:0] ARCH_GPRS,
	input wire logic [63:0] CAUSE_IP,
	output logic MEM_VALID,
	output logic [63:0] MEM_ADDR,
	output logic [63:0] MEM_DATA,
	input wire logic MEM_READY
);

	// ------------------------------------------------
	// Decoders
	// ------------------------------------------------
	function automatic logic precise_ok(input logic [7:0] ev, input logic [7:0] um);
		logic ok;
		ok = 1'b0;
		unique case (ev)
			PCPS_EV_BR: ok = um inside {8'h00, 8'h7E, 8'hFE, 8'hF9, 8'hFD, 8'hFB, 8'hEB,
				8'hBF, 8'hF7}; // RULE8
			PCPS_EV_MISP: ok = um inside {8'h00, 8'h7E, 8'hFE, 8'hFB, 8'hEB, 8'hF7}; // RULE9
			PCPS_EV_MEM: ok = um inside {8'h02, 8'h04, 8'h08, 8'h20}; // RULE10
			PCPS_EV_REHAB: ok = um inside {8'h01, 8'h08}; // RULE10
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	function automatic logic sel_hit(input logic [31:0] es, input logic [7:0] ev,
		input logic [7:0] um);
		return es[PCPS_ES_EN_BIT] && es[PCPS_ES_EVT_LSB +: 8] == ev
			&& es[PCPS_ES_UM_LSB +: 8] == um; // RULE3
	endfunction

	// ------------------------------------------------
	// Register state
	// ------------------------------------------------
	logic [31:0] es_q [PCPS_NUM_GP];
	logic [CW-1:0] ctr_q [PCPS_NUM_CTR];
	logic [PCPS_NUM_CTR-1:0] ovf_q;
	logic [PCPS_NUM_CTR-1:0] gen_q;
	logic psen_q;
	logic [63:0] base_q;
	logic [31:0] off_q [2];
	logic [31:0] fixctl_q;
	logic sample_pend_q;
	logic [4:0] slot_q;
	logic [63:0] rec_base_q;
	logic [63:0] wr_ptr_q;
	logic loading_q;
	logic [63:0] status_snap_q;
	pcps_state_t state_q;

	// ------------------------------------------------
	// APB decode
	// ------------------------------------------------
	wire bus_wr = CE && PSEL && PENABLE && PWRITE && PREADY;
	wire bus_rd = CE && PSEL && !PENABLE && !PWRITE;
	wire ctr_win = PADDR >= PCPS_A_CTR_BASE && PADDR < PCPS_A_CTR_BASE + 12'(8 * PCPS_NUM_CTR);
	wire [3:0] ctr_idx = 4'((PADDR - PCPS_A_CTR_BASE) >> 3);
	wire ctr_hi = PADDR[2];
	wire [2:0] ctr_sel = 3'(ctr_idx);
	wire mapped = PADDR[1:0] == 2'b00 && (PADDR <= PCPS_A_PEND || ctr_win);
	wire [31:0] cap_word = {8'h00, 8'(CW), 8'(PCPS_NUM_GP), PCPS_ARCH_VER}; // RULE2 RULE5
	wire [CW-1:0] ctr_rd = ctr_q[ctr_sel];
	wire [63:0] ctr_rd64 = 64'(ctr_rd);
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = '0;
		if (ctr_win) begin
			rd_mux = ctr_hi ? ctr_rd64[63:32] : ctr_rd64[31:0];
		end else begin
			unique case (PADDR)
				PCPS_A_ES0: rd_mux = es_q[0];
				PCPS_A_ES1: rd_mux = es_q[1];
				PCPS_A_STATUS: rd_mux = 32'(ovf_q); // RULE17
				PCPS_A_GCTRL: rd_mux = 32'(gen_q);
				PCPS_A_PSEN: rd_mux = 32'(psen_q);
				PCPS_A_BASE: rd_mux = base_q[31:0];
				PCPS_A_CAP: rd_mux = cap_word;
				PCPS_A_OFF0: rd_mux = off_q[0];
				PCPS_A_OFF1: rd_mux = off_q[1];
				PCPS_A_FIXCTL: rd_mux = fixctl_q;
				PCPS_A_PEND: rd_mux = {30'h0, state_q != PCPS_IDLE, sample_pend_q};
				default: rd_mux = '0;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PREADY <= 1'b0;
			PRDATA <= '0;
			PSLVERR <= 1'b0;
		end else if (CE) begin
			PREADY <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !mapped;
			if (bus_rd) begin
				PRDATA <= mapped ? rd_mux : '0;
			end
		end
	end

	// ------------------------------------------------
	// Event matching
	// ------------------------------------------------
	logic [PCPS_NUM_CTR-1:0] inc;
	logic [PCPS_NUM_GP-1:0] is_lat;
	genvar g;
	generate
		for (g = 0; g < PCPS_NUM_GP; g++) begin : g_gp
			// Off-core select only counts when its qualifier holds bits, except counter one in latency mode
			wire off_um0 = es_q[g][PCPS_ES_UM_LSB +: 8] == PCPS_UM_OFF0;
			wire off_sel = es_q[g][PCPS_ES_EVT_LSB +: 8] == PCPS_EV_OFFCORE;
			wire off_ok = off_um0 ? |off_q[0] : |off_q[1]; // RULE15
			// Latency mode: counter one sums outstanding weight
			assign is_lat[g] = (g == 1) && off_q[0][31] && off_sel; // RULE16
			assign inc[g] = gen_q[g] && EVT_VALID && (!off_sel || off_ok)
				&& sel_hit(es_q[g], EVT_CODE, EVT_UMASK); // RULE3 RULE4
		end
		for (g = 0; g < PCPS_NUM_FIX; g++) begin : g_fix
			assign inc[PCPS_NUM_GP+g] = gen_q[PCPS_NUM_GP+g] && fixctl_q[g] && FIX_EVT[g];
		end
	endgenerate

	wire pe_armed = psen_q && gen_q[0]
		&& precise_ok(es_q[0][PCPS_ES_EVT_LSB +: 8], es_q[0][PCPS_ES_UM_LSB +: 8]); // RULE6

	// ------------------------------------------------
	// Counters
	// ------------------------------------------------
	logic [PCPS_NUM_CTR-1:0] wrap;
	generate
		for (g = 0; g < PCPS_NUM_CTR; g++) begin : g_ctr
			wire [CW-1:0] step = (g == 1 && is_lat[1] && gen_q[1] && EVT_VALID)
				? CW'(LAT_WEIGHT) : CW'(inc[g]);
			wire [CW:0] sum = {1'b0, ctr_q[g]} + {1'b0, step};
			wire hit_lo = bus_wr && ctr_win && ctr_sel == 3'(g) && !ctr_hi;
			wire hit_hi = bus_wr && ctr_win && ctr_sel == 3'(g) && ctr_hi;
			assign wrap[g] = sum[CW]; // RULE1 RULE2
			always_ff @(posedge REF_CLK or negedge RST_N) begin
				if (!RST_N) begin
					ctr_q[g] <= '0;
				end else if (CE) begin
					if (hit_lo) begin
						ctr_q[g] <= {ctr_q[g][CW-1:32], PWDATA};
					end else if (hit_hi) begin
						ctr_q[g] <= {PWDATA[CW-33:0], ctr_q[g][31:0]};
					end else begin
						ctr_q[g] <= sum[CW-1:0];
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------
	// Control registers
	// ------------------------------------------------
	wire clr_wr = bus_wr && PADDR == PCPS_A_OVFCLR;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			es_q <= '{default: '0};
			off_q <= '{default: '0};
			ovf_q <= '0;
			gen_q <= '0;
			psen_q <= 1'b0;
			base_q <= '0;
			fixctl_q <= '0;
		end else if (CE) begin
			if (bus_wr && PADDR == PCPS_A_ES0) es_q[0] <= PWDATA & PCPS_ES_WMASK; // RULE4
			if (bus_wr && PADDR == PCPS_A_ES1) es_q[1] <= PWDATA & PCPS_ES_WMASK; // RULE4
			if (bus_wr && PADDR == PCPS_A_OFF0) off_q[0] <= PWDATA; // RULE15
			if (bus_wr && PADDR == PCPS_A_OFF1) off_q[1] <= PWDATA; // RULE15
			if (bus_wr && PADDR == PCPS_A_GCTRL) gen_q <= PWDATA[PCPS_NUM_CTR-1:0];
			if (bus_wr && PADDR == PCPS_A_PSEN) psen_q <= PWDATA[0];
			if (bus_wr && PADDR == PCPS_A_BASE) base_q <= 64'(PWDATA);
			if (bus_wr && PADDR == PCPS_A_FIXCTL) fixctl_q <= PWDATA;
			// Set wins over clear
			ovf_q <= (ovf_q & ~(clr_wr ? PWDATA[PCPS_NUM_CTR-1:0] : '0)) | wrap; // RULE17
		end
	end

	// ------------------------------------------------
	// Precise sample capture and record stream
	// ------------------------------------------------
	logic [63:0] slot_data;
	logic [4:0] rd_slot;
	logic [63:0] mem_rd;
	wire start = state_q == PCPS_IDLE && !loading_q && sample_pend_q && RETIRE_VALID;
	wire load_en = start || loading_q;
	wire beat_done = MEM_VALID && MEM_READY;
	wire last_slot = slot_q == 5'(PCPS_REC_WORDS - 1);
	wire slot_step = load_en || (state_q == PCPS_WRITE && beat_done);
	wire [4:0] slot_nx = slot_q + 5'h01;

	always_comb begin
		slot_data = '0; // RULE19
		if (slot_q == 5'(PCPS_SLOT_FLAGS)) slot_data = ARCH_FLAGS; // RULE12
		if (slot_q == 5'(PCPS_SLOT_IP)) slot_data = ARCH_IP; // RULE7 RULE12
		if (slot_q >= 5'(PCPS_SLOT_GPR0) && slot_q < 5'(PCPS_SLOT_STATUS))
			slot_data = ARCH_GPRS[64*(slot_q-5'(PCPS_SLOT_GPR0)) +: 64]; // RULE12
		if (slot_q == 5'(PCPS_SLOT_STATUS)) slot_data = status_snap_q; // RULE12
		if (slot_q == 5'(PCPS_SLOT_CAUSE)) slot_data = CAUSE_IP; // RULE18
	end

	// Read address runs one step ahead so registered data match slot_q
	assign rd_slot = !slot_step ? slot_q : last_slot ? 5'h00 : slot_nx;

	pcps_rec_mem #(.WIDTH(64), .DEPTH(PCPS_REC_WORDS), .AW(5)) u_mem (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.ce(CE),
		.wr_en(load_en),
		.wr_addr(slot_q),
		.wr_data(slot_data),
		.rd_addr(rd_slot),
		.rd_data(mem_rd)
	);

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sample_pend_q <= 1'b0;
			state_q <= PCPS_IDLE;
			slot_q <= '0;
			rec_base_q <= '0;
			wr_ptr_q <= '0;
			status_snap_q <= '0;
			loading_q <= 1'b0;
			MEM_VALID <= 1'b0;
			MEM_ADDR <= '0;
			MEM_DATA <= '0;
		end else if (CE) begin
			unique case (state_q)
				PCPS_IDLE: begin
					if (load_en) begin
						// Record taken from this retirement on, one slot a cycle
						loading_q <= 1'b1; // RULE7
						slot_q <= slot_nx;
						if (last_slot) begin
							slot_q <= '0;
							loading_q <= 1'b0;
							sample_pend_q <= 1'b0;
							state_q <= PCPS_WRITE;
						end
					end
					if (start) begin
						// Base fixed for the whole record
						rec_base_q <= wr_ptr_q; // RULE14
						wr_ptr_q <= wr_ptr_q + 64'(PCPS_REC_BYTES);
					end
				end
				PCPS_WRITE: begin
					// Gap cycle loads the beat, then it holds until taken
					if (!MEM_VALID) begin
						MEM_VALID <= 1'b1;
						MEM_ADDR <= rec_base_q + {56'h0, slot_q, 3'b000}; // RULE11 RULE14
						MEM_DATA <= mem_rd; // RULE11
					end else if (MEM_READY) begin
						MEM_VALID <= 1'b0;
						slot_q <= slot_nx;
						if (last_slot) begin
							slot_q <= '0;
							state_q <= PCPS_IDLE;
						end
					end
				end
			endcase
			// New base applies from the next record on
			if (bus_wr && PADDR == PCPS_A_BASE) wr_ptr_q <= 64'(PWDATA); // RULE14
			// Set wins over the clear at the end of loading
			if (pe_armed && wrap[0]) begin
				sample_pend_q <= 1'b1; // RULE6
				status_snap_q <= 64'(ovf_q | wrap);
			end
		end
	end

endmodule

// ===== testbench/pcps_top_properties.sv
// Purpose: Port checker for pcps_top
// Assumes: CE held high by the bench
// Notes: Beat counter gives the record slot
`timescale 1ns/1ps
module pcps_top_chk
	import pcps_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic MEM_VALID,
	input wire logic [63:0] MEM_ADDR,
	input wire logic [63:0] MEM_DATA,
	input wire logic MEM_READY
);
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	logic [4:0] beat_q;
	logic [63:0] last_q;
	wire take = MEM_VALID && MEM_READY;
	wire rd_ok = PSEL && PENABLE && PREADY && !PWRITE;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			beat_q <= 5'h00;
			last_q <= 64'h0;
		end else if (take) begin
			beat_q <= (beat_q == 5'h17) ? 5'h00 : beat_q + 5'h01;
			last_q <= MEM_ADDR;
		end
	end
	chk_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	chk_cap_fields: assert property (rd_ok && PADDR == PCPS_A_CAP |->
		PRDATA[23:0] == 24'h280203) else $error("capability fields wrong");
	chk_any_ignored: assert property (rd_ok && PADDR inside {12'h000, 12'h004} |->
		!PRDATA[21]) else $error("thread bit readable");
	chk_beat_hold: assert property (MEM_VALID && !MEM_READY |=>
		MEM_VALID && $stable(MEM_ADDR) && $stable(MEM_DATA)) else $error("beat changed");
	chk_beat_gap: assert property (take |=> !MEM_VALID)
		else $error("no gap after beat");
	chk_addr_step: assert property ($rose(MEM_VALID) && beat_q != 5'h00 |->
		MEM_ADDR == last_q + 64'h8) else $error("slot address step");
	chk_addr_align: assert property (MEM_VALID |-> MEM_ADDR[2:0] == 3'h0)
		else $error("slot misaligned");
	chk_rsvd_zero: assert property (MEM_VALID && beat_q inside {19, 20, 21, 23} |->
		MEM_DATA == 64'h0) else $error("reserved slot not zero");
endmodule

bind pcps_top pcps_top_chk pcps_top_chk_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
	.MEM_VALID(MEM_VALID), .MEM_ADDR(MEM_ADDR), .MEM_DATA(MEM_DATA), .MEM_READY(MEM_READY));

// ===== testbench/pcps_mem_sink.sv
// Purpose: Save-area memory taking record beats
// Assumes: Ready may drop at any edge
// Notes: Beats kept in queues for the bench
`timescale 1ns/1ps
module pcps_mem_sink (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic valid,
	input wire logic [63:0] addr,
	input wire logic [63:0] data,
	output logic ready
);
	logic [63:0] aq[$];
	logic [63:0] dq[$];
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready <= 1'b0;
		end else begin
			if (valid && ready) begin
				aq.push_back(addr);
				dq.push_back(data);
			end
			ready <= ($urandom % 3) != 0;
		end
	end
endmodule

// ===== testbench/perf_counter_precise_sampling_tb.sv
// Purpose: Self-checking bench for pcps_top
// Assumes: CE tied high
// Notes: Memory side stalls at random
`timescale 1ns/1ps
module perf_counter_precise_sampling_tb
	import pcps_pkg::*;
;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ev_v = 0, ret = 0, err;
	logic [11:0] pa = 0;
	logic [31:0] pwd = 0, rdat;
	logic [7:0] ec = 0, eu = 0, lw = 0;
	logic [2:0] fx = 0;
	logic [63:0] fl = 0, ip = 0, cip = 0, e[24];
	logic [1023:0] g = 0;
	wire [31:0] prd;
	wire prdy, perr, mv, mrdy;
	wire [63:0] ma, md;
	int n_mismatch = 0, n_tests = 0, cnt[5];
	localparam logic [15:0] PEV [21] = '{16'hC400, 16'hC47E, 16'hC4FE, 16'hC4F9, 16'hC4FD,
		16'hC4FB, 16'hC4EB, 16'hC4BF, 16'hC4F7, 16'hC500, 16'hC57E, 16'hC5FE, 16'hC5FB,
		16'hC5EB, 16'hC5F7, 16'h0402, 16'h0404, 16'h0408, 16'h0420, 16'h0301, 16'h0308};
	pcps_top #(.CW(40)) pcps_top_i (.REF_CLK(clk), .RST_N(rst_n), .CE(1'b1), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
		.PSLVERR(perr), .EVT_CODE(ec), .EVT_UMASK(eu), .EVT_VALID(ev_v), .FIX_EVT(fx),
		.LAT_WEIGHT(lw), .RETIRE_VALID(ret), .ARCH_FLAGS(fl), .ARCH_IP(ip), .ARCH_GPRS(g),
		.CAUSE_IP(cip), .MEM_VALID(mv), .MEM_ADDR(ma), .MEM_DATA(md), .MEM_READY(mrdy));
	pcps_mem_sink pcps_mem_sink_i (.clk(clk), .rst_n(rst_n), .valid(mv), .addr(ma),
		.data(md), .ready(mrdy));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task chk(input string nm, input logic [63:0] x, input logic [63:0] y);
		n_tests++;
		if (y !== x) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, x, y);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		rdat = prd;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, {32'h0, x}, {32'h0, rdat});
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		results();
	end
	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial begin
		int k, s, m, v, r;
		logic [7:0] f;
		void'($urandom(32'hEDEFBAC9));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(PCPS_A_CAP, 32'h00280203, "cap");
		apb(1'b1, PCPS_A_ES1, 32'h0060412E);
		rd(PCPS_A_ES1, 32'h0040412E, "es1");
		apb(1'b0, 12'h030, 32'h0);
		chk("slverr", 64'h1, {63'h0, err});
		$display("test registers done");
		apb(1'b1, PCPS_A_FIXCTL, 32'h7);
		apb(1'b1, PCPS_A_GCTRL, 32'h1E);
		cnt = '{default: 0};
		repeat (60) begin
			m = $urandom % 2;
			v = $urandom % 2;
			f = $urandom;
			ev_v <= v[0];
			ec <= m[0] ? 8'h2E : 8'h3A;
			eu <= 8'h41;
			fx <= f[2:0];
			lw <= $urandom;
			cnt[1] += v & m;
			for (k = 0; k < 3; k++) cnt[2 + k] += f[k];
			@(posedge clk);
		end
		ev_v <= 1'b0;
		fx <= 3'h0;
		@(posedge clk);
		apb(1'b1, PCPS_A_GCTRL, 32'h0);
		for (k = 1; k < 5; k++) rd(PCPS_A_CTR_BASE + 12'(8 * k), cnt[k], "ctr");
		apb(1'b1, PCPS_A_OFF0, 32'h80000001);
		apb(1'b1, PCPS_A_ES0, 32'h004001B7);
		apb(1'b1, PCPS_A_ES1, 32'h004001B7);
		apb(1'b1, PCPS_A_GCTRL, 32'h3);
		repeat (40) begin
			v = $urandom % 2;
			m = $urandom % 2;
			f = $urandom;
			ev_v <= v[0];
			ec <= 8'hB7;
			eu <= m[0] ? 8'h01 : 8'h02;
			lw <= f;
			cnt[0] += v & m;
			cnt[1] += v * f;
			@(posedge clk);
		end
		ev_v <= 1'b0;
		@(posedge clk);
		apb(1'b1, PCPS_A_GCTRL, 32'h0);
		rd(PCPS_A_CTR_BASE, cnt[0], "offcore");
		rd(PCPS_A_CTR_BASE + 12'h8, cnt[1], "latency");
		$display("test counters done");
		apb(1'b1, PCPS_A_BASE, 32'h4000);
		apb(1'b1, PCPS_A_PSEN, 32'h1);
		for (r = 0; r < 21; r++) begin
			apb(1'b1, PCPS_A_GCTRL, 32'h0);
			repeat (4) @(posedge clk);
			apb(1'b1, PCPS_A_ES0, {16'h0040, PEV[r][7:0], PEV[r][15:8]});
			apb(1'b1, PCPS_A_CTR_BASE, 32'hFFFFFFFF);
			apb(1'b1, PCPS_A_CTR_BASE + 12'h4, 32'hFF);
			apb(1'b1, PCPS_A_GCTRL, 32'h1);
			ev_v <= 1'b1;
			ec <= PEV[r][15:8];
			eu <= PEV[r][7:0];
			@(posedge clk);
			ev_v <= 1'b0;
			for (k = 0; k < 32; k++) g[32 * k +: 32] <= $urandom;
			fl <= {$urandom, $urandom};
			ip <= {$urandom, $urandom};
			cip <= {$urandom, $urandom};
			repeat (3) @(posedge clk);
			ret <= 1'b1;
			@(posedge clk);
			ret <= 1'b0;
			e = '{default: 64'h0};
			e[0] = fl;
			e[1] = ip;
			e[18] = 64'h1;
			e[22] = cip;
			for (k = 0; k < 16; k++) e[2 + k] = g[64 * k +: 64];
			if (r == 20) apb(1'b1, PCPS_A_BASE, 32'h9000);
			while (pcps_mem_sink_i.dq.size() < 24) begin
				@(posedge clk);
			end
			for (s = 0; s < 24; s++) begin
				chk("addr", 64'h4000 + 64'hC0 * r + 8 * s, pcps_mem_sink_i.aq.pop_front());
				chk("slot", e[s], pcps_mem_sink_i.dq.pop_front());
			end
			rd(PCPS_A_STATUS, 32'h1, "ovf");
			apb(1'b1, PCPS_A_OVFCLR, 32'h1);
			rd(PCPS_A_STATUS, 32'h0, "ovf clear");
		end
		$display("test sampling done");
		results();
	end
endmodule
